// >>> src/pelar_params.svh
// Offsets, field positions, masks and reset values of the event latch and
// accessory register slice. Included by the register bank module.
`ifndef PELAR_PARAMS_SVH
`define PELAR_PARAMS_SVH
// =====================================================================
// Register offsets (six-bit register address)
`define PELAR_A_LATCH 6'h14
`define PELAR_A_LINE 6'h15
`define PELAR_A_SCR 6'h16
`define PELAR_A_SW 6'h19
`define PELAR_A_IE 6'h1D
`define PELAR_OFS_SET 6'h01
`define PELAR_OFS_CLR 6'h02
// =====================================================================
// Implemented bits of each register
`define PELAR_LATCH_MASK 8'h1F
`define PELAR_SCR_MASK 8'hFF
`define PELAR_SW_MASK 8'hFE
`define PELAR_IE_MASK 8'h27
`define PELAR_RST_BYTE 8'h00
`define PELAR_ZERO6 6'h00
// =====================================================================
// Field positions
`define PELAR_LATCH_HOSTDISC 0
`define PELAR_SW_ID_DRV 1
`define PELAR_SW_TX 2
`define PELAR_SW_RX 3
`define PELAR_SW_LEFT 4
`define PELAR_SW_RIGHT 5
`define PELAR_SW_MIC 6
`define PELAR_SW_D2FLOAT 7
`define PELAR_IE_FRISE 0
`define PELAR_IE_FFALL 1
`define PELAR_IE_DPV 2
`define PELAR_IE_RID 5
`endif

// >>> src/pelar_pkg.sv
// Types shared by the event latch and accessory register slice.
// Assumes the includer also pulls in pelar_params.svh for the numbers.
package pelar_pkg;
   // =====================================================================
   // Kind of register access decoded from the address
   typedef enum logic [1:0] {
      PELAR_ACC_NONE,
      PELAR_ACC_WRITE,
      PELAR_ACC_SET,
      PELAR_ACC_CLEAR
   } pelar_acc_t;
endpackage

// >>> src/pelar_regs.sv
// Event latch, line state view, scratch byte, accessory switch control and
// accessory interrupt enables of the PHY register map.
// Assumes the ULPI register engine presents one-cycle read and write
// strobes with address and data, all synchronous to sys_clk_i.
//
// Overview of operation
// - Unmasked indicator edges set latch bits 0-4
// - Reading latch clears it; bits 7-5 zero
// - Line state view returns line state low
// - Scratch byte: write, set, clear, no effect
// - Switch control at 19h write, set, clear
// - Receive switch clear holds DATA1 high
// - Bits route TX, RX, ident pulldown; bit0 zero
// - Bit 4 connects DM to left speaker
// - DP to right speaker if bit5 or bit6
// - Bit 7 floats DATA2 in accessory mode
// - UART data to left speaker pin if bits 4 and 2 set; DP level to right if bit 3 and bit 5 or 6 set
// - Any audio switch disables single-ended receivers
// - Ident float edges raise alt interrupt
// - Enable bits 3,4,6,7 always read zero
// - Conversion done raises alt, ORed vendor enable
// - Interrupt enable at 1Dh write, set, clear
// - Rise or fall enable unmasks indicator events
`timescale 1ns/1ps
`include "pelar_params.svh"

module pelar_regs
   import pelar_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic clk_en_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic host_mode_i,
   input wire logic host_disc_i,
   input wire logic vbus_valid_i,
   input wire logic session_ok_i,
   input wire logic session_over_i,
   input wire logic ident_low_i,
   input wire logic [4:0] rise_en_i,
   input wire logic [4:0] fall_en_i,
   input wire logic [1:0] line_state_i,
   input wire logic accessory_mode_i,
   input wire logic ident_float_i,
   input wire logic dp_voltage_detect_i,
   input wire logic resistor_conv_done_i,
   input wire logic vendor_resistor_conv_irq_en_i,
   input wire logic uart_txd_i,
   input wire logic dp_level_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic [7:0] usb_event_latch_o,
   output logic alt_int_o,
   output logic ident_pulldown_drive_o,
   output logic uart_tx_switch_o,
   output logic uart_rx_switch_o,
   output logic left_audio_link_o,
   output logic right_audio_link_o,
   output logic se_rx_disable_o,
   output logic dm_data_o,
   output logic left_speaker_pin_o,
   output logic right_speaker_pin_o,
   output logic data1_o,
   output logic data1_oe_n_o,
   output logic data2_o,
   output logic data2_oe_n_o
);

   // =====================================================================
   // Helpers
   function automatic pelar_acc_t pelar_kind(input logic [5:0] addr,
                                             input logic [5:0] base);
      pelar_acc_t k;
      k = PELAR_ACC_NONE;
      if (addr == base)
      begin
         k = PELAR_ACC_WRITE;
      end
      else if (addr == base + `PELAR_OFS_SET)
      begin
         k = PELAR_ACC_SET;
      end
      else if (addr == base + `PELAR_OFS_CLR)
      begin
         k = PELAR_ACC_CLEAR;
      end
      return k;
   endfunction

   function automatic logic [7:0] pelar_apply(input pelar_acc_t k,
                                              input logic [7:0] old,
                                              input logic [7:0] wd,
                                              input logic [7:0] mask);
      logic [7:0] v;
      v = old;
      case (k)
         PELAR_ACC_WRITE: v = wd;
         PELAR_ACC_SET: v = old | wd;
         PELAR_ACC_CLEAR: v = old & ~wd;
         default: v = old;
      endcase
      return v & mask;
   endfunction

   // =====================================================================
   // State
   logic [7:0] latch;
   logic [7:0] scratch;
   logic [7:0] sw;
   logic [7:0] ie;
   logic [4:0] ind_q;
   logic float_q;
   logic dpv_q;
   logic rid_q;
   logic primed;

   // =====================================================================
   // Address decode
   wire pelar_acc_t scr_kind = pelar_kind(reg_addr_i, `PELAR_A_SCR);
   wire pelar_acc_t sw_kind = pelar_kind(reg_addr_i, `PELAR_A_SW);
   wire pelar_acc_t ie_kind = pelar_kind(reg_addr_i, `PELAR_A_IE);
   wire latch_hit = (reg_addr_i == `PELAR_A_LATCH);
   wire line_hit = (reg_addr_i == `PELAR_A_LINE);
   wire rd_latch = reg_rd_i && latch_hit;
   wire pelar_acc_t scr_wkind = reg_wr_i ? scr_kind : PELAR_ACC_NONE;
   wire pelar_acc_t sw_wkind = reg_wr_i ? sw_kind : PELAR_ACC_NONE;
   wire pelar_acc_t ie_wkind = reg_wr_i ? ie_kind : PELAR_ACC_NONE;

   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = `PELAR_RST_BYTE;
      if (latch_hit)
      begin
         rd_mux = latch;
      end
      else if (line_hit)
      begin
         rd_mux = {`PELAR_ZERO6, line_state_i};
      end
      else if (scr_kind != PELAR_ACC_NONE)
      begin
         rd_mux = scratch;
      end
      else if (sw_kind != PELAR_ACC_NONE)
      begin
         rd_mux = sw;
      end
      else if (ie_kind != PELAR_ACC_NONE)
      begin
         rd_mux = ie;
      end
   end

   // =====================================================================
   // Indicator edge events
   wire [4:0] ind = {ident_low_i, session_over_i, session_ok_i,
                     vbus_valid_i, host_disc_i};
   wire [4:0] ind_rise = ind & ~ind_q;
   wire [4:0] ind_fall = ~ind & ind_q;
   // Host disconnect only counts while acting as host
   wire [4:0] ind_gate = {4'hF, host_mode_i};
   wire [4:0] ind_ev = primed ?
      ((ind_rise & rise_en_i) | (ind_fall & fall_en_i)) & ind_gate :
      5'h00;
   // Set beats the clear of the read; the read returns the old value
   wire [7:0] next_latch =
      ((rd_latch ? `PELAR_RST_BYTE : latch) | {3'h0, ind_ev})
      & `PELAR_LATCH_MASK;

   // =====================================================================
   // Alternate interrupt sources
   wire float_up = ident_float_i && !float_q;
   wire float_dn = !ident_float_i && float_q;
   wire rid_up = resistor_conv_done_i && !rid_q;
   wire rid_en = ie[`PELAR_IE_RID] || vendor_resistor_conv_irq_en_i;
   wire alt_ev = primed && (
      (float_up && ie[`PELAR_IE_FRISE]) ||
      (float_dn && ie[`PELAR_IE_FFALL]) ||
      ((dp_voltage_detect_i ^ dpv_q) && ie[`PELAR_IE_DPV]) ||
      (rid_up && rid_en));

   // =====================================================================
   // Next register values
   wire [7:0] next_scratch =
      pelar_apply(scr_wkind, scratch, reg_wdata_i, `PELAR_SCR_MASK);
   wire [7:0] next_sw =
      pelar_apply(sw_wkind, sw, reg_wdata_i, `PELAR_SW_MASK);
   // Unimplemented enable bits are masked so they never store
   wire [7:0] next_ie =
      pelar_apply(ie_wkind, ie, reg_wdata_i, `PELAR_IE_MASK);

   // =====================================================================
   // Switch and pin steering
   wire audio_any = sw[`PELAR_SW_LEFT] || sw[`PELAR_SW_RIGHT] ||
                    sw[`PELAR_SW_MIC];
   wire right_link = sw[`PELAR_SW_RIGHT] || sw[`PELAR_SW_MIC];
   wire next_left_spk = sw[`PELAR_SW_LEFT] && sw[`PELAR_SW_TX] &&
                        uart_txd_i;
   wire next_right_spk = right_link && sw[`PELAR_SW_RX] &&
                         dp_level_i;
   // Receive switch open: DATA1 idles high so the link sees a quiet line
   wire next_data1 = sw[`PELAR_SW_RX] ? dp_level_i : 1'b1;
   // DATA2 float only applies once in accessory mode
   wire next_data2_oe_n = !(accessory_mode_i &&
                            !sw[`PELAR_SW_D2FLOAT]);

   // =====================================================================
   // Registers
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         latch <= `PELAR_RST_BYTE;
         scratch <= `PELAR_RST_BYTE;
         sw <= `PELAR_RST_BYTE;
         ie <= `PELAR_RST_BYTE;
      end
      else if (clk_en_i)
      begin
         latch <= next_latch;
         scratch <= next_scratch;
         sw <= next_sw;
         ie <= next_ie;
      end
   end

   // First enabled cycle only loads the history, so levels present at
   // reset release do not show up as false edges
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ind_q <= 5'h00;
         float_q <= 1'b0;
         dpv_q <= 1'b0;
         rid_q <= 1'b0;
         primed <= 1'b0;
      end
      else if (clk_en_i)
      begin
         ind_q <= ind;
         float_q <= ident_float_i;
         dpv_q <= dp_voltage_detect_i;
         rid_q <= resistor_conv_done_i;
         primed <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         reg_rdata_o <= `PELAR_RST_BYTE;
         reg_rvalid_o <= 1'b0;
         alt_int_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         reg_rdata_o <= reg_rd_i ? rd_mux : reg_rdata_o;
         reg_rvalid_o <= reg_rd_i;
         alt_int_o <= alt_ev;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         left_audio_link_o <= 1'b0;
         right_audio_link_o <= 1'b0;
         se_rx_disable_o <= 1'b0;
         dm_data_o <= 1'b0;
         left_speaker_pin_o <= 1'b0;
         right_speaker_pin_o <= 1'b0;
         data1_o <= 1'b1;
         data1_oe_n_o <= 1'b1;
         data2_o <= 1'b0;
         data2_oe_n_o <= 1'b1;
      end
      else if (clk_en_i)
      begin
         left_audio_link_o <= sw[`PELAR_SW_LEFT];
         right_audio_link_o <= right_link;
         se_rx_disable_o <= audio_any;
         dm_data_o <= uart_txd_i;
         left_speaker_pin_o <= next_left_spk;
         right_speaker_pin_o <= next_right_spk;
         data1_o <= next_data1;
         data1_oe_n_o <= !accessory_mode_i;
         data2_o <= 1'b0;
         data2_oe_n_o <= next_data2_oe_n;
      end
   end

   assign usb_event_latch_o = latch;
   assign ident_pulldown_drive_o = sw[`PELAR_SW_ID_DRV];
   assign uart_tx_switch_o = sw[`PELAR_SW_TX];
   assign uart_rx_switch_o = sw[`PELAR_SW_RX];

   // =====================================================================
   // Checks
   latch_set_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && primed && vbus_valid_i && !ind_q[1] && rise_en_i[1]
      |=> latch[1])
      else $error("rising bus-power edge not latched");

   host_gate_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && !host_mode_i && !latch[0] && !rd_latch
      |=> !latch[0])
      else $error("host disconnect latched outside host mode");

   latch_clear_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && rd_latch && (ind_ev == 5'h00)
      |=> (latch == 8'h00) && reg_rvalid_o
          && (reg_rdata_o == $past(latch)))
      else $error("latch read did not return and clear");

   line_view_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_rd_i && line_hit
      |=> reg_rdata_o == {6'h00, $past(line_state_i)})
      else $error("line state view wrong");

   scratch_set_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_wr_i && (reg_addr_i == 6'h17)
      |=> scratch == ($past(scratch) | $past(reg_wdata_i)))
      else $error("scratch set access wrong");

   switch_clear_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_wr_i && (reg_addr_i == 6'h1B)
      |=> sw == ($past(sw) & ~$past(reg_wdata_i) & 8'hFE))
      else $error("switch clear access wrong");

   data1_idle_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && accessory_mode_i && !sw[3]
      |=> data1_o && !data1_oe_n_o)
      else $error("DATA1 not held high");

   right_link_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i |=> right_audio_link_o == $past(sw[5] || sw[6]))
      else $error("right speaker link wrong");

   data2_float_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && accessory_mode_i
      |=> data2_oe_n_o == $past(sw[7]))
      else $error("DATA2 drive wrong in accessory mode");

   se_disable_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && (sw[6:4] != 3'h0) |=> se_rx_disable_o)
      else $error("receivers not disabled during audio");

   float_irq_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && primed && float_dn && ie[1] |=> alt_int_o)
      else $error("float fall did not raise alt interrupt");

   dp_irq_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && primed && (dp_voltage_detect_i != dpv_q) && ie[2]
      |=> alt_int_o)
      else $error("DP detect change did not raise alt interrupt");

   enable_rsv_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && reg_rd_i && (ie_kind != PELAR_ACC_NONE)
      |=> (reg_rdata_o & 8'hD8) == 8'h00)
      else $error("unimplemented enable bits read nonzero");

   rid_irq_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_en_i && primed && rid_up && vendor_resistor_conv_irq_en_i
      |=> alt_int_o)
      else $error("vendor enable did not raise alt interrupt");

endmodule

// >>> tb/pelar_link_model.sv
// Link-side register engine model: one-cycle read and write strobes.
// Assumes the block takes strobes on the rising edge of sys_clk_i and
// answers a read exactly one cycle later.
`timescale 1ns/1ps
module pelar_link_model
(
   input wire logic sys_clk_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   output logic [5:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o
);
   initial
   begin
      reg_addr_o = 6'h3F;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   // =====================================================================
   // Bus cycles; the idle address, and the data after a write, are inverted so stale values never help
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge sys_clk_i);
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d,
                     output logic v);
      @(negedge sys_clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge sys_clk_i);
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rdata_i;
      v = reg_rvalid_i;
   endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the event latch and accessory register slice.
// Assumes a link model drives the strobe port; bench drives the rest.
`timescale 1ns/1ps
`include "pelar_params.svh"
module tb;
   import pelar_pkg::*;
   logic sys_clk_i, arst_n_i, clk_en_i, reg_wr_i, reg_rd_i, host_mode_i;
   logic accessory_mode_i, ident_float_i, dp_voltage_detect_i;
   logic resistor_conv_done_i, vendor_resistor_conv_irq_en_i;
   logic uart_txd_i, dp_level_i, reg_rvalid_o, alt_int_o, dm_data_o;
   logic ident_pulldown_drive_o, uart_tx_switch_o, uart_rx_switch_o;
   logic left_audio_link_o, right_audio_link_o, se_rx_disable_o;
   logic left_speaker_pin_o, right_speaker_pin_o;
   logic data1_o, data1_oe_n_o, data2_o, data2_oe_n_o;
   logic [5:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, usb_event_latch_o;
   logic [4:0] rise_en_i, fall_en_i, ind;
   logic [1:0] line_state_i;
   wire logic host_disc_i, vbus_valid_i, session_ok_i;
   wire logic session_over_i, ident_low_i;
   logic [7:0] seed, r, d, m_latch, m_scr, m_sw, m_ie, ex;
   logic [5:0] b;
   logic v, e;
   int n_fail, samples_checked, i;
   assign {ident_low_i, session_over_i, session_ok_i, vbus_valid_i,
           host_disc_i} = ind;

   pelar_regs dut_u (.sys_clk_i, .arst_n_i, .clk_en_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .host_mode_i, .host_disc_i,
      .vbus_valid_i, .session_ok_i, .session_over_i, .ident_low_i,
      .rise_en_i, .fall_en_i, .line_state_i, .accessory_mode_i,
      .ident_float_i, .dp_voltage_detect_i, .resistor_conv_done_i,
      .vendor_resistor_conv_irq_en_i, .uart_txd_i, .dp_level_i,
      .reg_rdata_o, .reg_rvalid_o, .usb_event_latch_o, .alt_int_o,
      .ident_pulldown_drive_o, .uart_tx_switch_o, .uart_rx_switch_o,
      .left_audio_link_o, .right_audio_link_o, .se_rx_disable_o,
      .dm_data_o, .left_speaker_pin_o, .right_speaker_pin_o, .data1_o,
      .data1_oe_n_o, .data2_o, .data2_oe_n_o);

   pelar_link_model link_u (.sys_clk_i(sys_clk_i),
      .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
      .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
      .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));

   initial
   begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // =====================================================================
   // Helpers
   function automatic logic [7:0] nxt();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   task automatic chk(input string n, input logic [7:0] s,
                      input logic [7:0] x);
      samples_checked++;
      if (s !== x)
      begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask
   function automatic logic [7:0] m_rd(input logic [5:0] a);
      case (a)
         6'h14: return m_latch;
         6'h15: return {6'h00, line_state_i};
         6'h16, 6'h17, 6'h18: return m_scr;
         6'h19, 6'h1A, 6'h1B: return m_sw;
         6'h1D, 6'h1E, 6'h1F: return m_ie;
         default: return 8'h00;
      endcase
   endfunction
   task automatic rd_chk(input logic [5:0] a);
      link_u.rd(a, d, v);
      chk("rvalid", {7'h00, v}, 8'h01);
      chk("rdata", d, m_rd(a));
      if (a == `PELAR_A_LATCH)
         m_latch = 8'h00;
   endtask
   // Plain write, set or clear, then keep only implemented bits
   function automatic logic [7:0] upd(input logic [7:0] o, input int k,
                                      input logic [7:0] w,
                                      input logic [7:0] m);
      return (k == 0 ? w : k == 1 ? (o | w) : (o & ~w)) & m;
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #200000;
      n_fail++;
      close_out();
   end
   // =====================================================================
   // Main sequence
   initial
   begin
      n_fail = 0;
      samples_checked = 0;
      seed = 8'h25;
      {m_latch, m_scr, m_sw, m_ie} = 32'h0000_0000;
      {arst_n_i, host_mode_i, accessory_mode_i, ident_float_i} = 4'h0;
      {dp_voltage_detect_i, resistor_conv_done_i, uart_txd_i} = 3'h0;
      {vendor_resistor_conv_irq_en_i, dp_level_i} = 2'h0;
      clk_en_i = 1'b1;
      ind = 5'h00;
      rise_en_i = 5'h1F;
      fall_en_i = 5'h1F;
      line_state_i = 2'h2;
      repeat (8) @(negedge sys_clk_i);
      arst_n_i = 1'b1;
      chk("data pins", {4'h0, data1_o, data1_oe_n_o, data2_o, data2_oe_n_o},
          8'h0D);
      for (i = 6'h14; i <= 6'h1F; i++)
         rd_chk(i[5:0]);
      $display("test reset values done");
      // Clock enable low freezes state, so this write must not land
      clk_en_i = 1'b0;
      link_u.wr(`PELAR_A_SCR, 8'hA5);
      clk_en_i = 1'b1;
      rd_chk(`PELAR_A_SCR);
      $display("test clock enable done");
      // Read-only and unmapped places ignore writes
      for (i = 0; i < 8; i++)
      begin
         r = nxt();
         line_state_i = r[1:0];
         link_u.wr(6'h15, r);
         link_u.wr(6'h1C, ~r);
         link_u.wr(`PELAR_A_LATCH, r);
         rd_chk(6'h15);
         rd_chk(6'h1C);
         rd_chk(`PELAR_A_LATCH);
      end
      $display("test read-only done");
      for (i = 0; i < 90; i++)
      begin
         r = nxt();
         b = (r[1:0] == 2'h0) ? `PELAR_A_SCR :
             (r[1:0] == 2'h1) ? `PELAR_A_IE : `PELAR_A_SW;
         d = nxt();
         link_u.wr(b + 6'(r[3:2] % 3), d);
         if (b == `PELAR_A_SCR)
            m_scr = upd(m_scr, r[3:2] % 3, d, `PELAR_SCR_MASK);
         else if (b == `PELAR_A_IE)
            m_ie = upd(m_ie, r[3:2] % 3, d, `PELAR_IE_MASK);
         else
            m_sw = upd(m_sw, r[3:2] % 3, d, `PELAR_SW_MASK);
         // Mode only changes after the switch bits are in place
         // Overlapping UART and audio bits model UART use only
         r = nxt();
         {accessory_mode_i, uart_txd_i, dp_level_i} = r[2:0];
         repeat (2) @(negedge sys_clk_i);
         ex = {m_sw[1], m_sw[2], m_sw[3], m_sw[4], m_sw[5] | m_sw[6],
               |m_sw[6:4], m_sw[4] & m_sw[2] & r[1],
               (m_sw[5] | m_sw[6]) & m_sw[3] & r[0]};
         chk("switch pins", {ident_pulldown_drive_o, uart_tx_switch_o,
             uart_rx_switch_o, left_audio_link_o, right_audio_link_o,
             se_rx_disable_o, left_speaker_pin_o, right_speaker_pin_o},
             ex);
         ex = {3'h0, r[1], m_sw[3] ? r[0] : 1'b1, ~r[2], 1'b0,
               ~(r[2] & ~m_sw[7])};
         chk("data pins", {3'h0, dm_data_o, data1_o, data1_oe_n_o, data2_o,
             data2_oe_n_o}, ex);
         rd_chk(b + 6'(r[4:3] % 3));
      end
      $display("test register access done");
      for (i = 0; i < 40; i++)
      begin
         r = nxt();
         rise_en_i = r[4:0];
         fall_en_i = r[7:3];
         host_mode_i = r[5];
         @(negedge sys_clk_i);
         r = nxt();
         ex = {3'h0, (r[4:0] & ~ind & rise_en_i) |
                     (~r[4:0] & ind & fall_en_i)};
         ex[0] = ex[0] & host_mode_i;
         m_latch = m_latch | ex;
         ind = r[4:0];
         repeat (2) @(negedge sys_clk_i);
         chk("latch", usb_event_latch_o, m_latch);
         rd_chk(`PELAR_A_LATCH);
      end
      rd_chk(`PELAR_A_LATCH);
      $display("test event latch done");
      // ID pull-up is assumed enabled by the link
      for (i = 0; i < 48; i++)
      begin
         r = nxt();
         link_u.wr(`PELAR_A_IE, r);
         m_ie = r & `PELAR_IE_MASK;
         vendor_resistor_conv_irq_en_i = r[3];
         @(negedge sys_clk_i);
         d = nxt();
         e = (m_ie[0] & ~ident_float_i & d[0]) |
             (m_ie[1] & ident_float_i & ~d[0]) |
             (m_ie[2] & (dp_voltage_detect_i ^ d[1])) |
             ((m_ie[5] | r[3]) & ~resistor_conv_done_i & d[2]);
         {resistor_conv_done_i, dp_voltage_detect_i, ident_float_i} = d[2:0];
         // The pulse follows the edge that first sees the new levels
         @(negedge sys_clk_i);
         chk("alt", {7'h00, alt_int_o}, {7'h00, e});
         @(negedge sys_clk_i);
         chk("alt pulse end", {7'h00, alt_int_o}, 8'h00);
      end
      $display("test alt interrupt done");
      close_out();
   end
endmodule
